/* File: common/usbst_pkg.sv */
// constants for the start-of-frame timeout monitor: register map, fields, timing
// assumes a 250 MHz core clock and a 16-bit word-addressed register port
package usbst_pkg;

    // number of monitored peripheral ports
    localparam int unsigned NUM_PORTS = 2;

    // register word addresses as the device software sees them
    localparam logic [15:0] ADDR_P1_FRAME = 16'hc092;
    localparam logic [15:0] ADDR_P2_FRAME = 16'hc0b2;
    localparam logic [15:0] ADDR_P1_COUNT = 16'hc094;
    localparam logic [15:0] ADDR_P2_COUNT = 16'hc0b4;

    // widths of the fields
    localparam int unsigned COUNT_W = 14;
    localparam int unsigned FRAME_W = 11;
    localparam int unsigned OCC_W   = 3;
    localparam int unsigned DATA_W  = 16;

    // reset value of the interval count (1 ms at 12 MHz)
    localparam logic [13:0] COUNT_RESET = 14'h2ee0;
    localparam logic [13:0] COUNT_ZERO  = 14'h0000;
    localparam logic [13:0] COUNT_ONE   = 14'h0001;

    // timeout occurrence counter limits
    localparam logic [2:0] OCC_MAX  = 3'h7;
    localparam logic [2:0] OCC_ZERO = 3'h0;
    localparam logic [2:0] OCC_ONE  = 3'h1;

    // frame number register layout
    localparam int unsigned FRM_FLAG_BIT = 15;
    localparam int unsigned FRM_OCC_LSB  = 12;
    localparam int unsigned FRM_OCC_MSB  = 14;
    localparam int unsigned FRM_RSV_BIT  = 11;
    localparam int unsigned FRM_NUM_MSB  = 10;

    // fractional tick generator: 12 MHz ticks out of a 250 MHz clock
    localparam int unsigned CLK_RATE_MHZ  = 250;
    localparam int unsigned TICK_RATE_MHZ = 12;
    localparam int unsigned ACC_W         = 8;
    localparam logic [7:0]  TICK_STEP     = TICK_RATE_MHZ[7:0];
    localparam logic [7:0]  TICK_MODULUS  = CLK_RATE_MHZ[7:0];
    localparam logic [7:0]  ACC_ZERO      = 8'h00;

    // register image of one port
    typedef struct packed {
        logic [13:0] reload;    // programmed interval
        logic [13:0] down;      // running down counter
        logic [10:0] frame;     // last full-speed frame number
        logic        flag;      // timeout flag
        logic [2:0]  occ;       // consecutive timeout count
        logic        irq;       // timeout interrupt request
    } usbst_port_s;

endpackage : usbst_pkg

/* File: hdl/usbst_tick_gen.sv */
// 12 MHz tick generator derived from the core clock by a phase accumulator
// assumes one synchronous clock domain; ticks are one-cycle pulses
`timescale 1ns/1ps
module usbst_tick_gen
    import usbst_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    output logic      tick_o
);

    typedef struct packed {
        logic [7:0] acc;
        logic       tick;
    } usbst_tick_s;

    usbst_tick_s st;
    usbst_tick_s next_st;
    logic [8:0]  sum;

    // add the step each cycle, wrap at the clock rate and emit a tick on wrap
    always_comb begin
        next_st = st;
        sum     = {1'b0, st.acc} + {1'b0, TICK_STEP};
        if (sum >= {1'b0, TICK_MODULUS}) begin
            next_st.acc  = 8'(sum - {1'b0, TICK_MODULUS});
            next_st.tick = 1'b1;
        end else begin
            next_st.acc  = sum[7:0];
            next_st.tick = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_o = st.tick;

endmodule : usbst_tick_gen

/* File: hdl/usbst_monitor.sv */
// start-of-frame timeout monitor for two peripheral ports, with its registers
// assumes sof/eop strobes are one-cycle pulses synchronous to clock_i and a
// simple 16-bit register port: write strobe with data, read strobe answered
// one cycle later
//
// How it works
// - each timeout adds one to the three-bit occurrence counter, which holds at seven.
// - a received start-of-frame or end-of-packet clears the occurrence counter.
// - occurrence counter changes only while the port's timeout enable is set.
// - full-speed start-of-frame packets load their frame number into the field.
// - low-speed start-of-frame packets leave the frame field untouched.
// - a timeout keeps the last captured frame number unchanged.
// - down counter runs from the interval; expiry raises a timeout.
// - down counter decrements once per 12 MHz tick.
// - fourteen-bit interval count resets to 0x2ee0.
// - reading the count register returns the running down counter.
// - each port has its own count register at its own address.
// - a timeout sets the read-only flag in the frame number register.
// - a pulse on the port's tmo_flag_clr_i input clears a pending flag.
`timescale 1ns/1ps
module usbst_monitor
    import usbst_pkg::*;
(
    input  wire logic                    clock_i,
    input  wire logic                    rst_n_i,
    // register port
    input  wire logic [15:0]             reg_addr_i,
    input  wire logic                    reg_wr_i,
    input  wire logic [15:0]             reg_wdata_i,
    input  wire logic                    reg_rd_i,
    output logic      [15:0]             reg_rdata_o,
    output logic                         reg_rd_valid_o,
    // per-port link events
    input  wire logic [1:0]              sof_i,
    input  wire logic [1:0][10:0]        sof_frame_i,
    input  wire logic [1:0]              eop_i,
    input  wire logic [1:0]              low_speed_i,
    // per-port interrupt enable and input pulse that clears the pending flag
    input  wire logic [1:0]              tmo_int_en_i,
    input  wire logic [1:0]              tmo_flag_clr_i,
    // per-port timeout interrupt requests
    output logic      [1:0]              tmo_irq_o
);

    // whole state of the block
    typedef struct packed {
        usbst_port_s [1:0] port;
        logic [15:0]       rdata;
        logic              rd_valid;
    } usbst_state_s;

    usbst_state_s st;
    usbst_state_s next_st;
    logic         tick;

    // address decode and event detection results per port
    logic [1:0]   hit_count;
    logic [1:0]   hit_frame;
    logic [1:0]   timeout;
    logic [1:0]   frame_seen;

    // 12 MHz time base shared by both ports
    usbst_tick_gen u_tick (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .tick_o  (tick)
    );

    // register addresses per port
    always_comb begin
        hit_count[0] = (reg_addr_i == ADDR_P1_COUNT);
        hit_count[1] = (reg_addr_i == ADDR_P2_COUNT);
        hit_frame[0] = (reg_addr_i == ADDR_P1_FRAME);
        hit_frame[1] = (reg_addr_i == ADDR_P2_FRAME);
    end

    // per-port event detection
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            frame_seen[p] = sof_i[p] | eop_i[p];
            timeout[p]    = tick && (st.port[p].down == COUNT_ZERO);
        end
    end

    // next state of both ports and of the read path
    always_comb begin
        next_st = st;
        for (int p = 0; p < NUM_PORTS; p++) begin
            // down counter: a frame or an expiry reloads, a tick decrements
            if (frame_seen[p] || timeout[p]) begin
                next_st.port[p].down = st.port[p].reload;
            end else if (tick) begin
                next_st.port[p].down = st.port[p].down - COUNT_ONE;
            end

            // frame number capture, full speed only; timeouts leave it alone
            if (sof_i[p] && !low_speed_i[p]) begin
                next_st.port[p].frame = sof_frame_i[p];
            end

            // occurrence counter, gated by the interrupt enable
            if (tmo_int_en_i[p]) begin
                if (frame_seen[p]) begin
                    next_st.port[p].occ = OCC_ZERO;
                end else if (timeout[p] && st.port[p].occ != OCC_MAX) begin
                    next_st.port[p].occ = st.port[p].occ + OCC_ONE;
                end
            end

            // timeout flag: a new timeout wins over a clear in the same cycle
            if (timeout[p]) begin
                next_st.port[p].flag = 1'b1;
            end else if (tmo_flag_clr_i[p]) begin
                next_st.port[p].flag = 1'b0;
            end

            // interrupt request follows the pending flag while enabled
            next_st.port[p].irq = next_st.port[p].flag & tmo_int_en_i[p];

            // software write of the interval: store and restart the count
            if (reg_wr_i && hit_count[p]) begin
                next_st.port[p].reload = reg_wdata_i[13:0];
                next_st.port[p].down   = reg_wdata_i[13:0];
            end
        end

        // read path, answered in the cycle after the strobe
        next_st.rd_valid = reg_rd_i;
        next_st.rdata    = '0;
        if (reg_rd_i) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (hit_count[p]) begin
                    next_st.rdata = {2'b00, st.port[p].down};
                end else if (hit_frame[p]) begin
                    next_st.rdata[FRM_FLAG_BIT]               = st.port[p].flag;
                    next_st.rdata[FRM_OCC_MSB:FRM_OCC_LSB]    = st.port[p].occ;
                    next_st.rdata[FRM_RSV_BIT]                = 1'b0;
                    next_st.rdata[FRM_NUM_MSB:0]              = st.port[p].frame;
                end
            end
        end
    end

    // state register with reset values
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
            for (int p = 0; p < NUM_PORTS; p++) begin
                st.port[p].reload <= COUNT_RESET;
                st.port[p].down   <= COUNT_RESET;
            end
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign reg_rdata_o    = st.rdata;
    assign reg_rd_valid_o = st.rd_valid;
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            tmo_irq_o[p] = st.port[p].irq;
        end
    end

endmodule : usbst_monitor

/* File: bench/usbst_checker.sv */
// port assertions for the timeout monitor, bound to every usbst_monitor
// assumes the one-cycle read answer and pulse events of the monitor
`timescale 1ns/1ps
module usbst_checker
    import usbst_pkg::*;
(
    input wire logic             clock_i,
    input wire logic             rst_n_i,
    input wire logic [15:0]      reg_addr_i,
    input wire logic             reg_wr_i,
    input wire logic [15:0]      reg_wdata_i,
    input wire logic             reg_rd_i,
    input wire logic [15:0]      reg_rdata_o,
    input wire logic             reg_rd_valid_o,
    input wire logic [1:0]       sof_i,
    input wire logic [1:0][10:0] sof_frame_i,
    input wire logic [1:0]       eop_i,
    input wire logic [1:0]       low_speed_i,
    input wire logic [1:0]       tmo_int_en_i,
    input wire logic [1:0]       tmo_flag_clr_i,
    input wire logic [1:0]       tmo_irq_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // accesses and events of the first port
    sequence frm_rd; reg_rd_i && reg_addr_i == ADDR_P1_FRAME; endsequence
    sequence cnt_rd; reg_rd_i && reg_addr_i == ADDR_P1_COUNT; endsequence
    sequence cnt_wr; reg_wr_i && !reg_rd_i && reg_addr_i == ADDR_P1_COUNT; endsequence
    sequence fs_sof; sof_i[0] && !low_speed_i[0]; endsequence
    // register port answers, field layout and interrupt behaviour
    rd_answer_a: assert property (reg_rd_i |=> reg_rd_valid_o)
        else $error("read not answered");
    idle_quiet_a: assert property (!reg_rd_i |=> !reg_rd_valid_o && reg_rdata_o == 16'h0)
        else $error("read data without read");
    cnt_load_a: assert property (cnt_wr ##1 cnt_rd |=>
        reg_rdata_o == {2'h0, $past(reg_wdata_i[13:0], 2)}) else $error("count not loaded");
    cnt_rsv_a: assert property (cnt_rd |=> reg_rdata_o[15:14] == 2'h0)
        else $error("count reserved bits set");
    frm_cap_a: assert property (fs_sof ##1 frm_rd |=>
        reg_rdata_o[10:0] == $past(sof_frame_i[0], 2)) else $error("frame not captured");
    occ_clr_a: assert property ((sof_i[0] || eop_i[0]) && tmo_int_en_i[0] ##1 frm_rd |=>
        reg_rdata_o[14:12] == OCC_ZERO) else $error("occurrence count not cleared");
    irq_mask_a: assert property (!tmo_int_en_i[0] |=> !tmo_irq_o[0])
        else $error("masked interrupt raised");
    irq_hold_a: assert property (tmo_irq_o[0] && tmo_int_en_i[0] && !tmo_flag_clr_i[0]
        |=> tmo_irq_o[0]) else $error("interrupt dropped");
endmodule : usbst_checker

bind usbst_monitor usbst_checker chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rd_valid_o(reg_rd_valid_o),
    .sof_i(sof_i), .sof_frame_i(sof_frame_i), .eop_i(eop_i), .low_speed_i(low_speed_i),
    .tmo_int_en_i(tmo_int_en_i), .tmo_flag_clr_i(tmo_flag_clr_i), .tmo_irq_o(tmo_irq_o));

/* File: bench/usbst_host_model.sv */
// host side of the link: start-of-frame and end-of-packet pulses per port
// assumes the bench calls pkt; every change lands on a falling edge
`timescale 1ns/1ps
module usbst_host_model
    import usbst_pkg::*;
(
    input  wire logic        clock_i,
    output logic [1:0]       sof_o,
    output logic [1:0][10:0] frame_o,
    output logic [1:0]       eop_o,
    output logic [1:0]       low_speed_o
);
    initial begin
        sof_o = 2'h0;
        eop_o = 2'h0;
        frame_o = '0;
        low_speed_o = 2'h0;
    end
    // one-cycle packet; the frame lines change once the packet is over
    task automatic pkt(input int p, input logic [10:0] f, input logic ls, input logic e);
        @(negedge clock_i);
        low_speed_o[p] = ls;
        frame_o[p] = f;
        sof_o[p] = !e;
        eop_o[p] = e;
        @(negedge clock_i);
        sof_o[p] = 1'b0;
        eop_o[p] = 1'b0;
        frame_o[p] = ~f; // no stale frame after the packet
    endtask : pkt
endmodule : usbst_host_model

/* File: bench/test_usb_sof_timeout_monitor.sv */
// self-checking bench for the timeout monitor through its register port
// assumes the host model for link events and the bound checker
`timescale 1ns/1ps
module test_usb_sof_timeout_monitor
    import usbst_pkg::*;
;
    logic             clock_i = 1'b0;
    logic             rst_n_i = 1'b0;
    logic [15:0]      addr = 16'h0;
    logic [15:0]      wdata = 16'h0;
    logic             wr = 1'b0;
    logic             rd = 1'b0;
    logic [1:0]       en = 2'h0;
    logic [1:0]       clr = 2'h0;
    logic [15:0]      rdata, v, a;
    logic             valid;
    logic [1:0]       sof, eop, ls, irq;
    logic [1:0][10:0] frame;
    int               error_cnt = 0;
    int               comparisons = 0;
    usbst_host_model host (.clock_i(clock_i), .sof_o(sof), .frame_o(frame), .eop_o(eop),
        .low_speed_o(ls));
    usbst_monitor dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rd_valid_o(valid),
        .sof_i(sof), .sof_frame_i(frame), .eop_i(eop), .low_speed_i(ls),
        .tmo_int_en_i(en), .tmo_flag_clr_i(clr), .tmo_irq_o(irq));
    // 250 MHz clock
    initial begin
        forever #2 clock_i = ~clock_i;
    end
    // comparison, verdict and register access tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    task automatic rd_reg(input logic [15:0] ad, output logic [15:0] d);
        @(negedge clock_i);
        addr = ad;
        rd = 1'b1;
        @(negedge clock_i);
        rd = 1'b0;
        check({15'h0, valid}, 16'h1);
        d = rdata;
    endtask : rd_reg
    task automatic rd_chk(input logic [15:0] ad, input logic [15:0] exp);
        rd_reg(ad, v);
        check(v, exp);
    endtask : rd_chk
    task automatic wr_reg(input logic [15:0] ad, input logic [15:0] d);
        @(negedge clock_i);
        addr = ad;
        wdata = d;
        wr = 1'b1;
        @(negedge clock_i);
        wr = 1'b0;
    endtask : wr_reg
    task automatic wait_irq(input int p);
        int n = 0;
        while (irq[p] !== 1'b1) begin
            @(negedge clock_i);
            n++;
            if (n > 400) begin
                error_cnt++;
                $display("[FAIL] %0t ns: no timeout interrupt on port %0d", $time, p);
                conclude();
            end
        end
    endtask : wait_irq
    // main sequence
    initial begin
        repeat (10) @(posedge clock_i);
        @(negedge clock_i);
        rst_n_i = 1'b1;
        rd_chk(ADDR_P1_COUNT, 16'h2ee0);
        rd_chk(ADDR_P2_COUNT, 16'h2ee0);
        rd_chk(ADDR_P1_FRAME, 16'h0000);
        rd_chk(16'hc000, 16'h0000);
        rd_reg(ADDR_P2_COUNT, a);
        repeat (249) @(negedge clock_i);
        rd_reg(ADDR_P2_COUNT, v);
        check(a - v, 16'h000c);
        $display("reset and rate test done");
        // frame read in the cycle right behind the packet
        fork
            host.pkt(0, 11'h5a5, 1'b0, 1'b0);
            begin
                @(negedge clock_i);
                rd_chk(ADDR_P1_FRAME, 16'h05a5);
            end
        join
        host.pkt(0, 11'h123, 1'b1, 1'b0);
        rd_chk(ADDR_P1_FRAME, 16'h05a5);
        host.pkt(1, 11'h7ff, 1'b0, 1'b0);
        rd_chk(ADDR_P2_FRAME, 16'h07ff);
        $display("frame capture test done");
        // count read in the cycle right behind the write
        fork
            wr_reg(ADDR_P1_COUNT, 16'h0004);
            begin
                @(negedge clock_i);
                rd_chk(ADDR_P1_COUNT, 16'h0004);
            end
        join
        en = 2'h1;
        wait_irq(0);
        rd_chk(ADDR_P1_FRAME, 16'h95a5);
        repeat (1500) @(negedge clock_i);
        rd_chk(ADDR_P1_FRAME, 16'hf5a5);
        check({14'h0, irq}, 16'h0001);
        // end of packet, then frame read in the very next cycle
        fork
            host.pkt(0, 11'h000, 1'b1, 1'b1);
            begin
                @(negedge clock_i);
                rd_chk(ADDR_P1_FRAME, 16'h85a5);
            end
        join
        clr = 2'h1;
        @(negedge clock_i);
        clr = 2'h0;
        rd_chk(ADDR_P1_FRAME, 16'h05a5);
        $display("timeout test done");
        en = 2'h0;
        repeat (600) @(negedge clock_i);
        rd_reg(ADDR_P1_FRAME, v);
        check({13'h0, v[14:12]}, 16'h0000);
        $display("mask test done");
        conclude();
    end
endmodule : test_usb_sof_timeout_monitor
